//--- rtl/cys_calendar_switch.sv
/*
 * Calendar switch: 32 instances of four day-resolution channels, each
 * instance driving one output bit. A scan walks every channel on each
 * midnight date update and after power returns.
 * Assumes the date inputs are stable for a scan (256 clocks) after the
 * tick, years are counted from 2000, and the backup clock keeps them
 * valid while main power is down.
 */
`timescale 1ns/1ns
`include "cys_regs.svh"

module cys_calendar_switch
    import cys_pkg::*;
(
    input wire logic ref_clk_i, // 10 MHz clock
    input wire logic sys_rst_i, // sync reset, high
    input wire logic [4:0] cal_day_i, // day of month 1..31
    input wire logic [3:0] cal_month_i, // month 1..12
    input wire logic [6:0] cal_year_i, // year minus 2000
    input wire logic date_tick_i, // one-cycle pulse at midnight
    input wire logic power_ok_i, // main power present
    input wire logic [`CYS_INST_N-1:0] act_req_i, // activation-required option
    input wire logic [`CYS_INST_N-1:0] activate_i, // activate input per instance
    input wire logic cfg_wr_i, // setting write strobe
    input wire logic [4:0] cfg_inst_i, // instance to write
    input wire logic [1:0] cfg_chan_i, // channel A..D to write
    input wire logic [`CYS_ENT_W-1:0] cfg_data_i, // {off setting, on setting}
    output logic [`CYS_INST_N-1:0] switch_output_bit_o, // one bit per instance
    output logic scan_busy_o // scan in progress
);
    // =================================================================
    // state
    cys_state_t state_reg, state_next;
    logic mode_reg, mode_next; // 1: recompute levels, 0: events
    logic [7:0] idx_reg, idx_next; // {instance, channel, phase}
    logic tick_pend_reg, tick_pend_next;
    logic rec_pend_reg, rec_pend_next;
    logic pwr_reg, pwr_next;
    cys_date_t cur_date_reg, cur_date_next;
    cys_date_t prev_date_reg, prev_date_next;
    logic acc_on_reg, acc_on_next;
    logic acc_off_reg, acc_off_next;
    logic acc_lvl_reg, acc_lvl_next;
    logic hold_v_reg, hold_v_next;
    cys_set_t hold_reg, hold_next;
    logic [`CYS_INST_N-1:0] inst_state_reg, inst_state_next;
    logic [`CYS_INST_N-1:0] out_reg, out_next;
    logic busy_reg, busy_next;

    logic [`CYS_ENT_W-1:0] rd_data;
    logic [`CYS_INST_N-1:0] en_vec;
    logic [`CYS_INST_N-1:0] inst_sel;
    cys_set_t on_s, off_s, lo_s;
    logic [2:0] on_m, off_m;
    logic ev_on, ev_off, lvl_one, first_ch;
    logic on_all, off_all, lvl_all, proc, proc_last;

    // =================================================================
    // setting store
    cys_chan_mem u_mem (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(cfg_wr_i),
        .wr_addr_i({cfg_inst_i, cfg_chan_i}),
        .wr_data_i(cfg_data_i),
        .rd_addr_i(idx_reg[7:1]),
        .rd_data_o(rd_data)
    );

    // keep only the fields a setting uses; day granularity only
    function automatic cys_date_t date_key(input cys_date_t d, input logic [2:0] m);
        date_key = {d[`CYS_YR_HI:`CYS_YR_LO] & {7{m[2]}},
                    d[`CYS_MON_HI:`CYS_MON_LO] & {4{m[1]}},
                    d[`CYS_DAY_HI:`CYS_DAY_LO] & {5{m[0]}}};
    endfunction

    // =================================================================
    // channel evaluation
    always_comb begin
        en_vec = ~act_req_i | activate_i;
        inst_sel = `CYS_INST_N'(1) << idx_reg[7:3];
        on_s = rd_data[`CYS_ON_HI:`CYS_ON_LO];
        off_s = rd_data[`CYS_OFF_HI:`CYS_OFF_LO];
        on_m = on_s[`CYS_MASK_HI:`CYS_MASK_LO];
        off_m = off_s[`CYS_MASK_HI:`CYS_MASK_LO];
        proc = (state_reg == CYS_SCAN) && idx_reg[0];
        proc_last = proc && (idx_reg[2:1] == `CYS_LAST_CHAN);
        first_ch = (idx_reg[2:1] == 2'h0);
        // on event: first day whose key equals the on key
        ev_on = (|on_m)
            && (date_key(cur_date_reg, on_m) == date_key(on_s[15:0], on_m))
            && (date_key(prev_date_reg, on_m) != date_key(on_s[15:0], on_m));
        // off event: midnight after the off period has elapsed
        ev_off = (|off_m)
            && (date_key(prev_date_reg, off_m) == date_key(off_s[15:0], off_m))
            && (date_key(cur_date_reg, off_m) != date_key(off_s[15:0], off_m));
        // lower bound from own channel, or held on of previous channel
        lo_s = (|on_m) ? on_s : hold_reg;
        lvl_one = (|off_m) && ((|on_m) || (hold_v_reg && !first_ch))
            && (date_key(cur_date_reg, off_m) >= date_key(lo_s[15:0], off_m))
            && (date_key(cur_date_reg, off_m) <= date_key(off_s[15:0], off_m));
        on_all = (!first_ch && acc_on_reg) || ev_on;
        off_all = (!first_ch && acc_off_reg) || ev_off;
        lvl_all = (!first_ch && acc_lvl_reg) || lvl_one;
    end

    // =================================================================
    // scan sequencer
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        idx_next = idx_reg;
        tick_pend_next = tick_pend_reg | date_tick_i; // set wins
        rec_pend_next = rec_pend_reg | (power_ok_i & ~pwr_reg);
        pwr_next = power_ok_i;
        cur_date_next = cur_date_reg;
        prev_date_next = prev_date_reg;
        acc_on_next = acc_on_reg;
        acc_off_next = acc_off_reg;
        acc_lvl_next = acc_lvl_reg;
        hold_v_next = hold_v_reg;
        hold_next = hold_reg;
        inst_state_next = inst_state_reg;
        case (state_reg)
            CYS_IDLE: begin
                if (power_ok_i && (rec_pend_reg || tick_pend_reg)) begin
                    state_next = CYS_SCAN;
                    mode_next = rec_pend_reg;
                    idx_next = `CYS_SCAN_FIRST;
                    cur_date_next = {cal_year_i, cal_month_i, cal_day_i};
                    rec_pend_next = power_ok_i & ~pwr_reg;
                    tick_pend_next = date_tick_i;
                end
            end
            CYS_SCAN: begin
                idx_next = idx_reg + 8'h01;
                if (proc) begin
                    acc_on_next = on_all;
                    acc_off_next = off_all;
                    acc_lvl_next = lvl_all;
                    hold_v_next = (|on_m) && !(|off_m);
                    hold_next = on_s;
                    if (proc_last && power_ok_i && en_vec[idx_reg[7:3]]) begin
                        if (mode_reg) begin
                            inst_state_next[idx_reg[7:3]] = lvl_all;
                        end else if (off_all) begin
                            inst_state_next[idx_reg[7:3]] = 1'b0;
                        end else if (on_all) begin
                            inst_state_next[idx_reg[7:3]] = 1'b1;
                        end
                    end
                    if (idx_reg == `CYS_SCAN_LAST) begin
                        state_next = CYS_IDLE;
                        prev_date_next = cur_date_reg;
                    end
                end
            end
            default: begin
                state_next = CYS_IDLE;
            end
        endcase
        out_next = inst_state_next & en_vec & {`CYS_INST_N{power_ok_i}};
        busy_next = (state_next == CYS_SCAN);
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= CYS_IDLE;
            mode_reg <= 1'b0;
            idx_reg <= 8'h00;
            tick_pend_reg <= 1'b0;
            rec_pend_reg <= 1'b1;
            pwr_reg <= 1'b0;
            cur_date_reg <= 16'h0000;
            prev_date_reg <= 16'h0000;
            acc_on_reg <= 1'b0;
            acc_off_reg <= 1'b0;
            acc_lvl_reg <= 1'b0;
            hold_v_reg <= 1'b0;
            hold_reg <= 19'h00000;
            inst_state_reg <= 32'h00000000;
            out_reg <= 32'h00000000;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            idx_reg <= idx_next;
            tick_pend_reg <= tick_pend_next;
            rec_pend_reg <= rec_pend_next;
            pwr_reg <= pwr_next;
            cur_date_reg <= cur_date_next;
            prev_date_reg <= prev_date_next;
            acc_on_reg <= acc_on_next;
            acc_off_reg <= acc_off_next;
            acc_lvl_reg <= acc_lvl_next;
            hold_v_reg <= hold_v_next;
            hold_reg <= hold_next;
            inst_state_reg <= inst_state_next;
            out_reg <= out_next;
            busy_reg <= busy_next;
        end
    end

    assign switch_output_bit_o = out_reg;
    assign scan_busy_o = busy_reg;

    // =================================================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence full_scan;
        (state_reg == CYS_SCAN) ##255 (state_reg == CYS_SCAN) ##1 (state_reg == CYS_IDLE);
    endsequence

    power_open_a: assert property (!power_ok_i |=> switch_output_bit_o == 32'h0)
        else $error("output not open during power loss");
    power_freeze_a: assert property (!power_ok_i |=> $stable(inst_state_reg))
        else $error("switching during power loss");
    gate_off_a: assert property (1'b1 |=> (switch_output_bit_o & ~$past(en_vec)) == 32'h0)
        else $error("disabled instance output high");
    out_follow_a: assert property (power_ok_i |=>
        switch_output_bit_o == ($past(inst_state_next) & $past(en_vec)))
        else $error("output does not follow instance state");
    // the tick is latched first, so the scan starts two edges after it
    tick_scan_a: assert property ((state_reg == CYS_IDLE) && date_tick_i && power_ok_i
        |=> ##1 full_scan)
        else $error("date update did not scan all channels");
    rec_start_a: assert property ($rose(power_ok_i) |-> ##[1:260]
        (state_reg == CYS_SCAN && mode_reg))
        else $error("no recompute after power return");
    off_wins_a: assert property (proc_last && !mode_reg && power_ok_i
        && en_vec[idx_reg[7:3]] && off_all |=> (inst_state_reg & $past(inst_sel)) == 32'h0)
        else $error("off event did not clear instance");
    on_sets_a: assert property (proc_last && !mode_reg && power_ok_i
        && en_vec[idx_reg[7:3]] && on_all && !off_all
        |=> (inst_state_reg & $past(inst_sel)) == $past(inst_sel))
        else $error("on event did not set instance");
    lvl_load_a: assert property (proc_last && mode_reg && power_ok_i && en_vec[idx_reg[7:3]]
        |=> ((inst_state_reg & $past(inst_sel)) != 32'h0) == $past(lvl_all))
        else $error("recomputed level not loaded");
endmodule

//--- rtl/cys_regs.svh
/*
 * Constants of the calendar switch: memory layout, field positions,
 * scan figures and clock timing.
 * Assumes it is included by the package and by every design module.
 */
// Operation
// - thirty-two independent switch instances, each evaluated against the shared calendar.
// - each instance has four channels holding one on and one off setting.
// - all four channels of an instance drive one shared output bit.
// - settings resolve to whole days; no hour or minute is held.
// - on overlap the first on event sets the output, whatever channel.
// - the first off event clears the output, even if another range holds.
// - recurring switching by individual days, months or years is supported.
// - a recurring interval takes on and off from one single channel.
// - a continuous on period runs from a chosen day to a day/month/year end.
// - continuous period takes on from one channel, off from the next.
// - calendar date and time keep running from backup during power loss.
// - during power loss no switching happens and the output stays open.
// - a one on activate enables the instance when activation is required.
// - output is one exactly while the combined on condition holds; events set and clear it, off wins; only recompute scans load range levels.
// - with activation not required the instance always runs, activate ignored.
// - whole-year range turns on at year start, off after off year elapses.
`ifndef CYS_REGS_SVH
`define CYS_REGS_SVH

// =====================================================================
// sizes
`define CYS_INST_N 32
`define CYS_CHAN_N 4
`define CYS_ADDR_W 7
`define CYS_ENT_W 38
`define CYS_SET_W 19
`define CYS_KEY_W 16

// =====================================================================
// setting layout: {mask[2:0] = {year, month, day}, year, month, day}
`define CYS_DAY_LO 0
`define CYS_DAY_HI 4
`define CYS_MON_LO 5
`define CYS_MON_HI 8
`define CYS_YR_LO 9
`define CYS_YR_HI 15
`define CYS_MASK_LO 16
`define CYS_MASK_HI 18
`define CYS_ON_LO 0
`define CYS_ON_HI 18
`define CYS_OFF_LO 19
`define CYS_OFF_HI 37
`define CYS_YEAR_BASE 2000
`define CYS_YEAR_MAX 7'h63

// =====================================================================
// scan and timing
`define CYS_SCAN_FIRST 8'h00
`define CYS_SCAN_LAST 8'hff
`define CYS_LAST_CHAN 2'h3
`define CYS_CLK_PERIOD_NS 100
`define CYS_SCAN_CYCLES 256

`endif

//--- rtl/cys_pkg.sv
/*
 * Types of the calendar switch.
 * Assumes cys_regs.svh for the widths.
 */
`include "cys_regs.svh"

package cys_pkg;
    typedef logic [`CYS_KEY_W-1:0] cys_date_t;
    typedef logic [`CYS_SET_W-1:0] cys_set_t;
    typedef enum logic [0:0] {
        CYS_IDLE = 1'b0,
        CYS_SCAN = 1'b1
    } cys_state_t;
endpackage

//--- rtl/cys_chan_mem.sv
/*
 * Channel setting store: 128 entries, one per instance and channel.
 * Assumes one write port from configuration and one scan read port;
 * read data appear one clock after the address.
 */
`timescale 1ns/1ns
`include "cys_regs.svh"

module cys_chan_mem
    import cys_pkg::*;
(
    input wire logic ref_clk_i, // 10 MHz clock
    input wire logic sys_rst_i, // sync reset, high
    input wire logic wr_i, // write strobe
    input wire logic [`CYS_ADDR_W-1:0] wr_addr_i, // {instance, channel}
    input wire logic [`CYS_ENT_W-1:0] wr_data_i, // {off, on}
    input wire logic [`CYS_ADDR_W-1:0] rd_addr_i, // scan address
    output logic [`CYS_ENT_W-1:0] rd_data_o // registered read data
);
    logic [`CYS_ENT_W-1:0] mem_reg [0:(1<<`CYS_ADDR_W)-1];
    logic [`CYS_ENT_W-1:0] rd_reg;
    logic [`CYS_ENT_W-1:0] rd_next;

    always_comb begin
        rd_next = mem_reg[rd_addr_i];
    end

    always_ff @(posedge ref_clk_i) begin
        if (wr_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rd_reg <= '0;
        end else begin
            rd_reg <= rd_next;
        end
    end

    assign rd_data_o = rd_reg;
endmodule

//--- bench/cys_prog_model.sv
/*
 * Far-side model: the controller's calendar as the switch sees it.
 * A step request moves the date on by one day and pulses the tick.
 * Assumes step_i is a one-cycle pulse, no closer than one scan apart.
 */
`timescale 1ns/1ns

module cys_prog_model #(
    parameter int START_DAY = 30,
    parameter int START_MON = 12,
    parameter int START_YR = 24
) (
    input wire logic ref_clk_i, // 10 MHz clock
    input wire logic sys_rst_i, // sync reset, high
    input wire logic step_i, // advance one day
    output logic [4:0] cal_day_o, // day 1..31
    output logic [3:0] cal_month_o, // month 1..12
    output logic [6:0] cal_year_o, // year minus 2000
    output logic date_tick_o // midnight pulse
);
    logic [4:0] last_day;

    // =====================================================================
    // month length, leap years every fourth year
    always_comb begin
        case (cal_month_o)
            4'h2: last_day = (cal_year_o[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: last_day = 5'h1e;
            default: last_day = 5'h1f;
        endcase
    end

    // =====================================================================
    // date keeps running whatever the main power does
    always_ff @(posedge ref_clk_i) begin
        date_tick_o <= 1'b0;
        if (sys_rst_i) begin
            cal_day_o <= 5'(START_DAY);
            cal_month_o <= 4'(START_MON);
            cal_year_o <= 7'(START_YR);
        end else if (step_i) begin
            date_tick_o <= 1'b1;
            if (cal_day_o != last_day) begin
                cal_day_o <= cal_day_o + 5'h01;
            end else begin
                cal_day_o <= 5'h01;
                if (cal_month_o != 4'hc) begin
                    cal_month_o <= cal_month_o + 4'h1;
                end else begin
                    cal_month_o <= 4'h1;
                    // never beyond the last usable year
                    cal_year_o <= (cal_year_o == 7'h63) ? 7'h63 : cal_year_o + 7'h01;
                end
            end
        end
    end
endmodule

//--- bench/cys_calendar_switch_tb_top.sv
/*
 * Testbench of the calendar switch: configures channels, steps the
 * calendar day by day and checks every instance's output bit.
 * Assumes the calendar model starts on 30 December of year 24.
 */
`timescale 1ns/1ns
`include "cys_regs.svh"

module cys_calendar_switch_tb_top;
    import cys_pkg::*;
    localparam logic [31:0] FOLLOW = 32'h8000_0051;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic step = 1'b0;
    logic power_ok = 1'b0;
    logic cfg_wr = 1'b0;
    logic [4:0] cfg_inst = 5'h00;
    logic [1:0] cfg_chan = 2'h0;
    logic [`CYS_ENT_W-1:0] cfg_data = '0;
    logic [31:0] act_req = 32'h0000_0018;
    logic [31:0] activate = 32'h0000_0010;
    logic [4:0] cal_day;
    logic [3:0] cal_month;
    logic [6:0] cal_year;
    logic date_tick;
    logic [31:0] sw_out;
    logic scan_busy;
    int fails = 0;
    int checks_done = 0;

    always #50 ref_clk = ~ref_clk;

    cys_prog_model MODEL (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .step_i(step),
        .cal_day_o(cal_day), .cal_month_o(cal_month), .cal_year_o(cal_year),
        .date_tick_o(date_tick));

    cys_calendar_switch DUT (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .cal_day_i(cal_day),
        .cal_month_i(cal_month), .cal_year_i(cal_year), .date_tick_i(date_tick),
        .power_ok_i(power_ok), .act_req_i(act_req), .activate_i(activate),
        .cfg_wr_i(cfg_wr), .cfg_inst_i(cfg_inst), .cfg_chan_i(cfg_chan),
        .cfg_data_i(cfg_data), .switch_output_bit_o(sw_out), .scan_busy_o(scan_busy));

    // =====================================================================
    // helpers
    function automatic cys_set_t mk(input logic [2:0] m, input logic [6:0] y,
        input logic [3:0] mo, input logic [4:0] d);
        return {m, y, mo, d};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cfg(input int inst, input int chan, input cys_set_t on, input cys_set_t off);
        @(posedge ref_clk);
        #10;
        cfg_wr = 1'b1;
        cfg_inst = 5'(inst);
        cfg_chan = 2'(chan);
        cfg_data = {off, on};
    endtask

    // waits until the sequencer has been idle two edges in a row, so a
    // queued scan that starts right behind the first one is waited for too
    task automatic wait_scan;
        int n;
        int quiet;
        n = 0;
        quiet = 0;
        while (scan_busy !== 1'b1 && n < 10) begin
            @(posedge ref_clk);
            n++;
        end
        while (quiet < 2 && n < 1200) begin
            @(posedge ref_clk);
            n++;
            quiet = (scan_busy === 1'b0) ? quiet + 1 : 0;
        end
        @(posedge ref_clk);
        #10;
        if (n >= 1200) begin
            fails++;
            $display("[FAIL] scan end expected 0 seen 1");
        end
    endtask

    task automatic next_day(input string what, input logic [31:0] exp);
        @(posedge ref_clk);
        #10;
        step = 1'b1;
        @(posedge ref_clk);
        #10;
        step = 1'b0;
        wait_scan();
        check(what, sw_out, exp);
        $display("test %s done", what);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // =====================================================================
    // watchdog, about two and a half times the expected run
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        $display("[FAIL] watchdog expected done seen hang");
        stop_test();
    end

    // =====================================================================
    // tests
    initial begin
        repeat (20) @(posedge ref_clk);
        #10;
        sys_rst = 1'b0;
        check("out after reset", sw_out, 32'h0);
        for (int i = 0; i < 128; i++) begin
            cfg(i / 4, i % 4, '0, '0);
        end
        for (int k = 0; k < 32; k++) begin
            if (FOLLOW[k] || k == 3) begin
                cfg(k, 0, mk(3'h1, 7'h00, 4'h0, 5'h01), mk(3'h1, 7'h00, 4'h0, 5'h02));
            end
        end
        cfg(1, 1, mk(3'h7, 7'h18, 4'hc, 5'h1f), '0);
        cfg(1, 2, '0, mk(3'h7, 7'h19, 4'h1, 5'h01));
        cfg(2, 0, mk(3'h1, 7'h00, 4'h0, 5'h01), mk(3'h1, 7'h00, 4'h0, 5'h01));
        cfg(2, 3, mk(3'h1, 7'h00, 4'h0, 5'h02), mk(3'h1, 7'h00, 4'h0, 5'h03));
        cfg(5, 0, mk(3'h4, 7'h19, 4'h0, 5'h00), mk(3'h4, 7'h19, 4'h0, 5'h00));
        cfg(7, 0, mk(3'h2, 7'h00, 4'h1, 5'h00), mk(3'h2, 7'h00, 4'h1, 5'h00));
        @(posedge ref_clk);
        #10;
        cfg_wr = 1'b0;
        check("out power low", sw_out, 32'h0);
        $display("test configure done");
        power_ok = 1'b1;
        wait_scan();
        check("recompute 12/30", sw_out, 32'h0);
        next_day("day 12/31", 32'h0000_0002);
        next_day("day 01/01", FOLLOW | 32'h0000_00a6);
        next_day("day 01/02", FOLLOW | 32'h0000_00a0);
        @(posedge ref_clk);
        #10;
        power_ok = 1'b0;
        repeat (3) @(posedge ref_clk);
        #10;
        check("out power lost", sw_out, 32'h0);
        step = 1'b1;
        @(posedge ref_clk);
        #10;
        step = 1'b0;
        repeat (20) @(posedge ref_clk);
        #10;
        check("out tick power lost", {sw_out[31:1], scan_busy}, 32'h0);
        check("date in loss", {27'h0, cal_day}, 32'h0000_0003);
        $display("test power loss done");
        power_ok = 1'b1;
        wait_scan();
        check("recompute 01/03", sw_out, 32'h0000_00a4);
        $display("test power return done");
        stop_test();
    end
endmodule
